/* logic/ipr_pkg.sv */
// Notes on behaviour
// - The first priority register keeps the breakpoint unit 0 level in bits 13:12, levels 1 to 3.
// - The first priority register keeps the step counter level in bits 11:10, levels 1 to 3.
// - The second priority register keeps the debug receive-full level in bits 5:4, levels 1 to 3.
// - The second priority register keeps the debug transmit-empty level in bits 3:2, levels 1 to 3.
// - The second priority register keeps the trace buffer level in bits 1:0, levels 1 to 3.
// - In a level 1 to 3 field, 01 means level 1, 10 means level 2 and 11 means level 3.
// - The third priority register keeps the flash buffers-empty level in bits 15:14, levels 0 to 2.
// - The third priority register keeps the flash command-done level in bits 13:12, levels 0 to 2.
// - The third priority register keeps the flash error level in bits 11:10, levels 0 to 2.
// - The third priority register keeps the PLL unlock level in bits 9:8, levels 0 to 2.
// - The third priority register keeps the low-voltage level in bits 7:6, levels 0 to 2.
// - The third priority register keeps the external request A level in bits 1:0, levels 0 to 2.
// - In a level 0 to 2 field, 01 means level 0, 10 means level 1 and 11 means level 2.
// - A field of 00 disables its source, and every field resets to 00.
// - Unimplemented bits read as zero and ignore writes in all four registers.
// - The fourth priority register keeps the CAN message buffer level in bits 9:8, levels 0 to 2.
`default_nettype none

package ipr_pkg;

  // Register bus shape
  localparam int          IPR_ADDR_W = 5;
  localparam int          IPR_DATA_W = 16;
  localparam int          IPR_NUM_REG = 4;
  localparam int          IPR_NUM_SRC = 12;
  localparam int          IPR_SRC_W = 4;

  // Register offsets
  localparam logic [4:0]  IPR_OFS_DEBUG_A  = 5'h00;
  localparam logic [4:0]  IPR_OFS_DEBUG_B  = 5'h01;
  localparam logic [4:0]  IPR_OFS_SYSTEM   = 5'h02;
  localparam logic [4:0]  IPR_OFS_CAN      = 5'h03;

  // Reset value of every priority register
  localparam logic [15:0] IPR_RESET_VALUE  = 16'h0000;

  // Implemented bits per register; all others read zero
  localparam logic [15:0] IPR_WMASK_DEBUG_A = 16'h3c00;
  localparam logic [15:0] IPR_WMASK_DEBUG_B = 16'h003f;
  localparam logic [15:0] IPR_WMASK_SYSTEM  = 16'hffc3;
  localparam logic [15:0] IPR_WMASK_CAN     = 16'h0300;

  // Field encodings
  localparam logic [1:0]  IPR_FLD_OFF = 2'h0;
  localparam logic [1:0]  IPR_BASE_HI = 2'h1;
  localparam logic [1:0]  IPR_BASE_LO = 2'h0;

  // Source table, index order: breakpoint0, step counter, debug rx full,
  // debug tx empty, trace buffer, flash buffers empty, flash cmd done,
  // flash error, pll unlock, low voltage, external req a, can msgbuf
  localparam int          IPR_SRC_REG  [IPR_NUM_SRC] = '{0, 0, 1, 1, 1, 2, 2, 2, 2, 2, 2, 3};
  localparam int          IPR_SRC_LSB  [IPR_NUM_SRC] = '{12, 10, 4, 2, 0, 14, 12, 10, 8, 6, 0, 8};
  localparam logic [1:0]  IPR_SRC_BASE [IPR_NUM_SRC] = '{2'h1, 2'h1, 2'h1, 2'h1, 2'h1,
                                                         2'h0, 2'h0, 2'h0, 2'h0, 2'h0,
                                                         2'h0, 2'h0};

endpackage : ipr_pkg

`default_nettype wire

/* logic/ipr_level_dec.sv */
`default_nettype none

module ipr_level_dec
  import ipr_pkg::*;
#(
  parameter logic [1:0] LEVEL_BASE = IPR_BASE_LO  // Level meant by code 01
) (
  input  wire logic [1:0] field,   // Priority field from register
  output logic            enable,  // Source allowed to request
  output logic [1:0]      level    // Decoded priority level
);

  // 00 disables; 01..11 count up from the base level
  always_comb begin
    enable = (field != IPR_FLD_OFF);
    if (field == IPR_FLD_OFF) begin
      level = 2'h0;
    end else begin
      level = 2'(field - 2'h1 + LEVEL_BASE);
    end
  end

endmodule : ipr_level_dec

`default_nettype wire

/* logic/ipr_req_arbiter.sv */
`default_nettype none

module ipr_req_arbiter
  import ipr_pkg::*;
#(
  parameter int NUM_SRC = IPR_NUM_SRC  // Number of request lines
) (
  input  wire logic                     clock,       // System clock
  input  wire logic                     arst_n,      // Async reset, low
  input  wire logic [NUM_SRC-1:0]       req_valid,   // Enabled requests
  input  wire logic [NUM_SRC-1:0][1:0]  req_level,   // Level per request
  input  wire logic [1:0]               core_mask,   // Core interrupt mask
  output logic                          irq_pending, // Winner present
  output logic [IPR_SRC_W-1:0]          irq_source,  // Winner index
  output logic [1:0]                    irq_level    // Winner level
);

  typedef struct packed {
    logic                 pending;
    logic [IPR_SRC_W-1:0] source;
    logic [1:0]           level;
  } ipr_arb_state_t;

  ipr_arb_state_t st_r;
  ipr_arb_state_t st_nxt;

  // Highest permitted level wins; lowest index breaks a tie
  always_comb begin
    st_nxt = '0;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (req_valid[i] && (req_level[i] >= core_mask)) begin
        if (!st_nxt.pending || (req_level[i] > st_nxt.level)) begin
          st_nxt.pending = 1'b1;
          st_nxt.source  = IPR_SRC_W'(i);
          st_nxt.level   = req_level[i];
        end
      end
    end
  end

  // State register
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign irq_pending = st_r.pending;
  assign irq_source  = st_r.source;
  assign irq_level   = st_r.level;

endmodule : ipr_req_arbiter

`default_nettype wire

/* logic/ipr_regs_top.sv */
`default_nettype none

module ipr_regs_top
  import ipr_pkg::*;
(
  input  wire logic                        clock,       // 40 MHz system clock
  input  wire logic                        arst_n,      // Async reset, low
  input  wire logic [IPR_ADDR_W-1:0]       reg_addr,    // Register index
  input  wire logic [IPR_DATA_W-1:0]       reg_wdata,   // Write data
  input  wire logic                        reg_wr,      // Write strobe
  input  wire logic                        reg_rd,      // Read strobe
  output logic [IPR_DATA_W-1:0]            reg_rdata,   // Read data, next cycle
  input  wire logic [IPR_NUM_SRC-1:0]      src_req,     // Raw source requests
  input  wire logic [1:0]                  core_mask,   // Core interrupt mask
  output logic [IPR_NUM_SRC-1:0]           req_valid,   // Gated requests
  output logic [IPR_NUM_SRC-1:0][1:0]      req_level,   // Level per request
  output logic                             irq_pending, // Winning request
  output logic [IPR_SRC_W-1:0]             irq_source,  // Winning index
  output logic [1:0]                       irq_level    // Winning level
);

  typedef struct packed {
    logic [IPR_NUM_REG-1:0][IPR_DATA_W-1:0] regs;
    logic [IPR_DATA_W-1:0]                  rdata;
    logic [IPR_NUM_SRC-1:0]                 valid;
    logic [IPR_NUM_SRC-1:0][1:0]            level;
  } ipr_top_state_t;

  ipr_top_state_t                st_r;
  ipr_top_state_t                st_nxt;
  logic [IPR_NUM_SRC-1:0]        dec_en;
  logic [IPR_NUM_SRC-1:0][1:0]   dec_lvl;

  // Offset of a register index
  function automatic logic [IPR_ADDR_W-1:0] ipr_reg_ofs(input int idx);
    unique case (idx)
      0:       ipr_reg_ofs = IPR_OFS_DEBUG_A;
      1:       ipr_reg_ofs = IPR_OFS_DEBUG_B;
      2:       ipr_reg_ofs = IPR_OFS_SYSTEM;
      default: ipr_reg_ofs = IPR_OFS_CAN;
    endcase
  endfunction : ipr_reg_ofs

  // Implemented bits of a register index
  function automatic logic [IPR_DATA_W-1:0] ipr_reg_mask(input int idx);
    unique case (idx)
      0:       ipr_reg_mask = IPR_WMASK_DEBUG_A;
      1:       ipr_reg_mask = IPR_WMASK_DEBUG_B;
      2:       ipr_reg_mask = IPR_WMASK_SYSTEM;
      default: ipr_reg_mask = IPR_WMASK_CAN;
    endcase
  endfunction : ipr_reg_mask

  // Field decoders, one per source
  for (genvar g = 0; g < IPR_NUM_SRC; g++) begin : g_src
    logic [1:0] fld;
    assign fld = st_r.regs[IPR_SRC_REG[g]][IPR_SRC_LSB[g] +: 2];
    ipr_level_dec #(
      .LEVEL_BASE (IPR_SRC_BASE[g])
    ) u_dec (
      .field  (fld),
      .enable (dec_en[g]),
      .level  (dec_lvl[g])
    );
  end

  // Register writes, read data and request gating
  always_comb begin
    st_nxt       = st_r;
    st_nxt.rdata = '0;
    for (int i = 0; i < IPR_NUM_REG; i++) begin
      if (reg_wr && (reg_addr == ipr_reg_ofs(i))) begin
        st_nxt.regs[i] = reg_wdata & ipr_reg_mask(i);
      end
      if (reg_rd && (reg_addr == ipr_reg_ofs(i))) begin
        st_nxt.rdata = st_r.regs[i] & ipr_reg_mask(i);
      end
    end
    st_nxt.valid = src_req & dec_en;
    for (int i = 0; i < IPR_NUM_SRC; i++) begin
      st_nxt.level[i] = dec_en[i] ? dec_lvl[i] : 2'h0;
    end
  end

  // State register; all fields start disabled
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st_r.regs  <= {IPR_NUM_REG{IPR_RESET_VALUE}};
      st_r.rdata <= '0;
      st_r.valid <= '0;
      st_r.level <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Picks the request handed to the core
  ipr_req_arbiter #(
    .NUM_SRC (IPR_NUM_SRC)
  ) u_arb (
    .clock       (clock),
    .arst_n      (arst_n),
    .req_valid   (st_r.valid),
    .req_level   (st_r.level),
    .core_mask   (core_mask),
    .irq_pending (irq_pending),
    .irq_source  (irq_source),
    .irq_level   (irq_level)
  );

  assign reg_rdata = st_r.rdata;
  assign req_valid = st_r.valid;
  assign req_level = st_r.level;

endmodule : ipr_regs_top

`default_nettype wire

/* verif/ipr_src_model.sv */
`default_nettype none

module ipr_src_model
  import ipr_pkg::*;
(
  input  wire logic                   clock,   // System clock
  input  wire logic                   arst_n,  // Async reset, low
  input  wire logic [IPR_NUM_SRC-1:0] pattern, // Requests to raise
  output logic      [IPR_NUM_SRC-1:0] src_req  // Level requests
);
  // Sources hold level requests, updated each rising edge
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) src_req <= '0;
    else src_req <= pattern;
  end
endmodule : ipr_src_model

`default_nettype wire

/* verif/ipr_regs_props.sv */
`default_nettype none

module ipr_regs_props
  import ipr_pkg::*;
(
  input wire logic                        clock,       // Clock
  input wire logic                        arst_n,      // Reset, low
  input wire logic [IPR_ADDR_W-1:0]       reg_addr,    // Index
  input wire logic                        reg_rd,      // Read strobe
  input wire logic [IPR_DATA_W-1:0]       reg_rdata,   // Read data
  input wire logic [IPR_NUM_SRC-1:0]      src_req,     // Raw requests
  input wire logic [1:0]                  core_mask,   // Core mask
  input wire logic [IPR_NUM_SRC-1:0]      req_valid,   // Gated requests
  input wire logic [IPR_NUM_SRC-1:0][1:0] req_level,   // Levels
  input wire logic                        irq_pending, // Winner flag
  input wire logic [IPR_SRC_W-1:0]        irq_source,  // Winner index
  input wire logic [1:0]                  irq_level    // Winner level
);
  logic [IPR_NUM_SRC-1:0]      rv_q;
  logic [IPR_NUM_SRC-1:0][1:0] rl_q;
  logic [1:0]                  best;
  logic                        any;
  function automatic logic [15:0] wmask(input logic [4:0] a);
    case (a)
      IPR_OFS_DEBUG_A: wmask = IPR_WMASK_DEBUG_A;
      IPR_OFS_DEBUG_B: wmask = IPR_WMASK_DEBUG_B;
      IPR_OFS_SYSTEM:  wmask = IPR_WMASK_SYSTEM;
      IPR_OFS_CAN:     wmask = IPR_WMASK_CAN;
      default:         wmask = 16'h0000;
    endcase
  endfunction : wmask
  // Best eligible level this cycle
  always_comb begin
    best = 2'h0;
    any = 1'b0;
    for (int i = 0; i < IPR_NUM_SRC; i++) begin
      if (req_valid[i] && req_level[i] >= core_mask && (!any || req_level[i] > best)) begin
        any = 1'b1;
        best = req_level[i];
      end
    end
  end
  // Requests one cycle back
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rv_q <= '0;
      rl_q <= '0;
    end else begin
      rv_q <= req_valid;
      rl_q <= req_level;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  sequence s_rd; reg_rd ##1 1'b1; endsequence
  AST_RD_IDLE: assert property (!reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data not zero outside read");
  AST_RD_MASK: assert property (s_rd |-> (reg_rdata & ~wmask($past(reg_addr))) == 16'h0000)
    else $error("unimplemented bits read nonzero");
  AST_GATE: assert property (1'b1 |=> (req_valid & ~$past(src_req)) == '0)
    else $error("request passed without source");
  AST_PEND: assert property (any |=> irq_pending && irq_level == $past(best))
    else $error("eligible request not raised at best level");
  AST_IDLE: assert property (!any |=> !irq_pending && irq_source == '0 && irq_level == 2'h0)
    else $error("pending without eligible request");
  AST_WIN: assert property (irq_pending |-> rv_q[irq_source] && rl_q[irq_source] == irq_level)
    else $error("winner not a valid request");
  AST_MASK: assert property (irq_pending |-> irq_level >= $past(core_mask))
    else $error("winner below core mask");
  AST_SRC_RANGE: assert property (irq_pending |-> irq_source < 4'hc)
    else $error("winner index out of range");
endmodule : ipr_regs_props

bind ipr_regs_top ipr_regs_props u_props (.clock, .arst_n, .reg_addr, .reg_rd, .reg_rdata,
  .src_req, .core_mask, .req_valid, .req_level, .irq_pending, .irq_source, .irq_level);

`default_nettype wire

/* verif/tb.sv */
`default_nettype none

module tb
  import ipr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {int at; logic [35:0] val; logic [1:0] kind;} ipr_note_t;
  localparam logic [15:0] WMASK [4] = '{16'h3c00, 16'h003f, 16'hffc3, 16'h0300};
  logic                        clock = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [4:0]                  reg_addr = '0;
  logic [15:0]                 reg_wdata = '0, reg_rdata;
  logic [11:0]                 pattern = '0, src_req, req_valid;
  logic [11:0][1:0]            req_level;
  logic [1:0]                  core_mask = '0, irq_level;
  logic                        irq_pending;
  logic [3:0]                  irq_source;
  logic [15:0]                 regs [4] = '{default: 16'h0};
  int                          cyc = 0, bad_count = 0, checks = 0;
  ipr_note_t                   notes [$];
  ipr_regs_top DUT (.clock, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .src_req, .core_mask, .req_valid, .req_level, .irq_pending, .irq_source, .irq_level);
  ipr_src_model u_src (.clock, .arst_n, .pattern, .src_req);
  // Clock
  initial forever #12.5 clock = ~clock;
  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_sim
  // One bus cycle; a read notes its expected data
  task automatic bus(input logic w, input logic r, input logic [4:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= a;
    reg_wdata <= d;
    if (w && a < 5'h04) regs[a] = d & WMASK[a];
    if (r) notes.push_back('{cyc + 2, {20'h0, d}, 2'h0});
  endtask : bus
  // Raise requests, note levels and winner
  task automatic apply(input logic [11:0] p, input logic [1:0] m);
    logic [35:0] lv;
    logic [1:0]  f;
    logic [6:0]  w;
    bus(1'b0, 1'b0, 5'h00, 16'h0000);
    pattern <= p;
    core_mask <= m;
    lv = '0;
    w = '0;
    for (int i = 0; i < 12; i++) begin
      f = regs[IPR_SRC_REG[i]][IPR_SRC_LSB[i] +: 2];
      lv[24+i] = p[i] && f != 2'h0;
      lv[2*i +: 2] = (f == 2'h0 || i < 5) ? f : f - 2'h1;
    end
    for (int i = 11; i >= 0; i--) begin
      if (lv[24+i] && lv[2*i +: 2] >= m && (!w[6] || lv[2*i +: 2] >= w[1:0])) w = {1'b1, i[3:0], lv[2*i +: 2]};
    end
    notes.push_back('{cyc + 3, lv, 2'h1});
    notes.push_back('{cyc + 4, {29'h0, w}, 2'h2});
    repeat (4) @(posedge clock);
  endtask : apply
  // Compare due notes, oldest first
  always @(negedge clock) begin
    while (notes.size() > 0 && notes[0].at == cyc) begin
      case (notes[0].kind)
        2'h0: check({20'h0, reg_rdata}, notes[0].val);
        2'h1: check({req_valid, req_level}, notes[0].val);
        default: check({29'h0, irq_pending, irq_source, irq_level}, notes[0].val);
      endcase
      void'(notes.pop_front());
    end
  end
  // Cycle count and hang limit
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 1000) begin
      bad_count++;
      end_sim();
    end
  end
  initial begin
    void'($urandom(65));
    repeat (2) @(posedge clock);
    arst_n <= 1'b1;
    for (int a = 0; a < 6; a++) bus(1'b0, 1'b1, a[4:0], 16'h0000);
    $display("test reset values done");
    for (int a = 0; a < 5; a++) begin
      bus(1'b1, 1'b0, a[4:0], 16'hffff);
      bus(1'b0, 1'b1, a[4:0], a < 4 ? regs[a[1:0]] : 16'h0000);
    end
    bus(1'b1, 1'b0, 5'h04, 16'h0000);
    bus(1'b0, 1'b1, 5'h00, regs[0]);
    $display("test field layout done");
    for (int c = 0; c < 4; c++) begin
      for (int a = 0; a < 4; a++) bus(1'b1, 1'b0, a[4:0], 16'h5555 * 16'(c));
      apply(12'hfff, c[1:0]);
    end
    $display("test encodings done");
    for (int n = 0; n < 30; n++) begin
      for (int a = 0; a < 4; a++) bus(1'b1, 1'b0, a[4:0], 16'($urandom()));
      apply(12'($urandom()), 2'($urandom()));
    end
    $display("test random done");
    repeat (4) @(posedge clock);
    end_sim();
  end
endmodule : tb

`default_nettype wire
